/* verilog/dswk_pkg.sv */
package dswk_pkg;
  // Bus geometry
  localparam int AXI_DW = 32;
  localparam int RESP_W = 2;
  localparam int REG_W = 8;
  localparam int FLAG_W = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_WAKE_LOW = 14'h0F4A;
  localparam logic [13:0] IDX_WAKE_HIGH = 14'h0F4B;
  localparam logic [13:0] IDX_SCRATCH0 = 14'h0F4E;
  localparam logic [13:0] IDX_SCRATCH1 = 14'h0F4F;
  localparam logic [13:0] IDX_WDOG_CTRL = 14'h0F40;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h0F41;
  localparam logic [13:0] IDX_IRQ_CLR = 14'h0F42;
  localparam logic [13:0] IDX_IRQ_EN = 14'h0F43;
  // Wake flag positions; bit 8 is the high register's bit 0
  localparam int WK_POR = 0;
  localparam int WK_MASTER_CLEAR_PIN = 2;
  localparam int WK_ALARM = 3;
  localparam int WK_WDOG = 4;
  localparam int WK_ULP = 5;
  localparam int WK_FAULT = 7;
  localparam int WK_PIN = 8;
  localparam logic [8:0] WK_IMPL = 9'h1BD;
  localparam logic [8:0] WK_RESET = 9'h001;
  // Watchdog control fields
  localparam int WDC_ULP_EN = 2;
  localparam int WDC_SINK = 4;
  localparam int WDC_LVL = 5;
  localparam logic [7:0] WDC_RESET = 8'h00;
  // Interrupt status positions
  localparam int IRQ_ULP_SLEEP = 0;
  localparam int IRQ_DS_LOG = 1;
  localparam int IRQ_LOST = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
endpackage : dswk_pkg

/* verilog/dswk_wake_if.sv */
`timescale 1ns/1ps
interface dswk_wake_if;
  logic deep_sleep;
  logic [8:0] src;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic [8:0] flags;
  logic logged;
  logic new_log;
  modport ctl (output deep_sleep, src, wr_low, wr_high, wdata, input flags, logged, new_log);
  modport logger (input deep_sleep, src, wr_low, wr_high, wdata, output flags, logged, new_log);
endinterface : dswk_wake_if

/* verilog/dswk_wake_log.sv */
`timescale 1ns/1ps
module dswk_wake_log (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Wake event and flag carrier
  dswk_wake_if.logger wk
);
  import dswk_pkg::*;

  logic [8:0] flags_ff;
  logic logged_ff;
  logic [8:0] cand;
  logic [8:0] pick;
  logic [8:0] set_v;
  logic [8:0] wmask;
  logic [8:0] wval;
  logic [8:0] nxt_flags;
  logic nxt_logged;

  // Lowest position wins a tie, so exactly one source is logged
  assign cand = wk.src & WK_IMPL;
  assign pick = cand & (~cand + 9'h001);
  // Outside deep sleep only the power-on flag may set
  assign set_v = wk.deep_sleep ? (logged_ff ? 9'h000 : pick)
                               : (cand & WK_RESET); // see [RULE10] see [RULE18]
  assign wmask = {wk.wr_high, {8{wk.wr_low}}};
  assign wval = {wk.wdata[0], wk.wdata} & WK_IMPL;
  // Hardware set wins over a software write in the same cycle
  assign nxt_flags = set_v | (wmask & wval) | (~wmask & flags_ff); // see [RULE19]
  assign nxt_logged = wk.deep_sleep & (logged_ff | (|pick));

  // Flags and first-source latch
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flags_ff <= WK_RESET; // see [RULE9] see [RULE11]
      logged_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags & WK_IMPL; // see [RULE11]
      logged_ff <= nxt_logged;
    end
  end

  assign wk.flags = flags_ff;
  assign wk.logged = logged_ff;
  assign wk.new_log = |set_v & wk.deep_sleep;
endmodule : dswk_wake_log

/* verilog/dswk_top.sv */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// [RULE1] Two byte-wide scratch registers, software read and write, kept through deep sleep
// [RULE2] Scratch lost only on core brown-out, deep-sleep brown-out trip, or supply cycling
// [RULE3] High wake register bit 0 logs pin-change wake in deep sleep; others zero
// [RULE4] Low wake register bit 7 logs a fault found during deep sleep
// [RULE5] Low wake register bit 5 logs an ultra low-power wake in deep sleep
// [RULE6] Low wake register bit 4 logs deep-sleep watchdog timeout
// [RULE7] Low wake register bit 3 logs a calendar alarm in deep sleep
// [RULE8] Low wake register bit 2 logs master clear pin asserted in deep sleep
// [RULE9] Low wake register bit 0 logs an active power-on detect; resets to one
// [RULE10] Power-on flag may set even outside deep sleep
// [RULE11] Low wake bits 6 and 1 read zero; other flags reset to zero
// [RULE12] Low-power wake from ordinary sleep sets the level flag in watchdog control
// [RULE13] Low-power wake from deep sleep sets the wake-status flag instead
// [RULE14] Sense input below threshold raises an interrupt that wakes from sleep
// [RULE15] In ordinary sleep the wake level is driven out for external detection
// [RULE16] Software charges the sense capacitor, then releases the pin before discharge
// [RULE17] Software sets module enable and current sink together to start discharge
// [RULE18] With several sources, only the first to assert is logged
// [RULE19] Each wake flag clears on a software zero write and otherwise holds; here a software one write sets the flag
module dswk_top #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [dswk_pkg::AXI_DW-1:0] s_axi_wdata_in,
  input wire logic [dswk_pkg::AXI_DW/8-1:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [dswk_pkg::RESP_W-1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [dswk_pkg::AXI_DW-1:0] s_axi_rdata_out,
  output logic [dswk_pkg::RESP_W-1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Power state
  input wire logic deep_sleep_in,
  input wire logic sleep_in,
  // Wake sources
  input wire logic pin_change_in,
  input wire logic fault_in,
  input wire logic ds_watchdog_timeout_in,
  input wire logic alarm_in,
  input wire logic master_clear_pin_in,
  input wire logic por_active_in,
  input wire logic por_detect_in,
  // Sense pin comparator, high while below the low threshold
  input wire logic sense_low_in,
  // Retention supply monitors
  input wire logic core_brownout_in,
  input wire logic deep_sleep_brownout_en_in,
  input wire logic deep_sleep_brownout_trip_in,
  input wire logic supply_cycle_in,
  // Wake and interrupt outputs
  output logic wake_level_output_out,
  output logic current_sink_out,
  output logic sleep_wake_irq_out,
  output logic irq_out
);
  import dswk_pkg::*;

  if (ADDR_W < 16)
  begin : g_bad_addr
    $error("ADDR_W must be at least 16");
  end

  dswk_wake_if wk ();

  logic aw_hold_ff;
  logic w_hold_ff;
  logic bvalid_ff;
  logic awready_ff;
  logic wready_ff;
  logic [13:0] waddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [AXI_DW-1:0] rdata_ff;
  logic rresp_err_ff;
  logic bresp_err_ff;
  logic [7:0] scratch0_ff;
  logic [7:0] scratch1_ff;
  logic [7:0] wdc_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic irq_ff;
  logic wake_lvl_ff;
  logic sink_ff;
  logic sleep_irq_ff;

  // Write channel handshakes; address and data may arrive in either order
  wire aw_hs = s_axi_awvalid_in & awready_ff;
  wire w_hs = s_axi_wvalid_in & wready_ff;
  wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire nxt_aw_hold = (aw_hold_ff | aw_hs) & ~do_write;
  wire nxt_w_hold = (w_hold_ff | w_hs) & ~do_write;
  wire nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready_in);
  wire ar_hs = s_axi_arvalid_in & arready_ff;
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready_in);

  // Write decode; only byte lane 0 carries register data
  wire wr_en = do_write & wlane_ff;
  wire wr_low = wr_en & (waddr_ff == IDX_WAKE_LOW);
  wire wr_high = wr_en & (waddr_ff == IDX_WAKE_HIGH);
  wire wr_scr0 = wr_en & (waddr_ff == IDX_SCRATCH0);
  wire wr_scr1 = wr_en & (waddr_ff == IDX_SCRATCH1);
  wire wr_wdc = wr_en & (waddr_ff == IDX_WDOG_CTRL);
  wire wr_iclr = wr_en & (waddr_ff == IDX_IRQ_CLR);
  wire wr_ien = wr_en & (waddr_ff == IDX_IRQ_EN);
  wire w_hit = wr_low | wr_high | wr_scr0 | wr_scr1 | wr_wdc | wr_iclr | wr_ien;
  wire w_map = (waddr_ff == IDX_WAKE_LOW) | (waddr_ff == IDX_WAKE_HIGH)
             | (waddr_ff == IDX_SCRATCH0) | (waddr_ff == IDX_SCRATCH1)
             | (waddr_ff == IDX_WDOG_CTRL) | (waddr_ff == IDX_IRQ_STAT)
             | (waddr_ff == IDX_IRQ_CLR) | (waddr_ff == IDX_IRQ_EN);

  // Read decode; the clear register is write-only and reads zero
  wire [13:0] ridx = s_axi_araddr_in[15:2];
  wire r_map = (ridx == IDX_WAKE_LOW) | (ridx == IDX_WAKE_HIGH)
             | (ridx == IDX_SCRATCH0) | (ridx == IDX_SCRATCH1)
             | (ridx == IDX_WDOG_CTRL) | (ridx == IDX_IRQ_STAT)
             | (ridx == IDX_IRQ_CLR) | (ridx == IDX_IRQ_EN);
  wire [7:0] rd_byte =
      (ridx == IDX_WAKE_LOW) ? wk.flags[7:0] :
      (ridx == IDX_WAKE_HIGH) ? {7'h00, wk.flags[WK_PIN]} : // see [RULE3]
      (ridx == IDX_SCRATCH0) ? scratch0_ff :
      (ridx == IDX_SCRATCH1) ? scratch1_ff :
      (ridx == IDX_WDOG_CTRL) ? wdc_ff :
      (ridx == IDX_IRQ_STAT) ? {5'h00, irq_stat_ff} :
      (ridx == IDX_IRQ_EN) ? {5'h00, irq_en_ff} : 8'h00;

  // Scratch loss: core brown-out outside deep sleep, an enabled deep-sleep brown-out trip, or supply cycling wipes both bytes
  wire lose = (core_brownout_in & ~deep_sleep_in)
            | (deep_sleep_in & deep_sleep_brownout_en_in & deep_sleep_brownout_trip_in)
            | supply_cycle_in; // see [RULE2]

  // Discharge runs only with both enable and sink set by software
  wire ulp_armed = wdc_ff[WDC_ULP_EN] & wdc_ff[WDC_SINK]; // see [RULE17]
  wire ulp_fire = ulp_armed & sense_low_in;
  wire in_sleep = sleep_in & ~deep_sleep_in;
  wire ulp_sleep_wake = in_sleep & ulp_fire; // see [RULE14]
  wire ulp_ds_wake = deep_sleep_in & ulp_fire; // see [RULE13]
  wire por_evt = por_active_in & por_detect_in; // see [RULE9]

  // Wake source vector toward the logger
  assign wk.deep_sleep = deep_sleep_in;
  assign wk.src = {pin_change_in, fault_in, 1'b0, ulp_ds_wake, ds_watchdog_timeout_in,
                   alarm_in, master_clear_pin_in, 1'b0, por_evt};
  assign wk.wr_low = wr_low;
  assign wk.wr_high = wr_high;
  assign wk.wdata = wbyte_ff;

  dswk_wake_log u_log (
    .clk_in (sys_clk_in),
    .nrst_in (nrst_in),
    .wk (wk)
  );

  // Interrupt events; set wins over the clear register
  wire [IRQ_W-1:0] irq_set = {lose, wk.new_log, ulp_sleep_wake};
  wire [IRQ_W-1:0] irq_clr = wr_iclr ? wbyte_ff[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);
  // Level flag: hardware set wins over software writes
  wire [7:0] nxt_wdc = (wr_wdc ? wbyte_ff : wdc_ff)
                     | (ulp_sleep_wake ? 8'(1 << WDC_LVL) : 8'h00); // see [RULE12]

  // Write path handshake state
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_err_ff <= 1'b0;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff <= ~nxt_w_hold & ~nxt_bvalid;
      if (do_write)
        bresp_err_ff <= ~w_map;
    end
  end

  // Captured write address and data
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      waddr_ff <= '0;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end
    else
    begin
      if (aw_hs)
        waddr_ff <= s_axi_awaddr_in[15:2];
      if (w_hs)
      begin
        wbyte_ff <= s_axi_wdata_in[7:0];
        wlane_ff <= s_axi_wstrb_in[0];
      end
    end
  end

  // Read path; one cycle from address to data
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_err_ff <= 1'b0;
    end
    else
    begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs)
      begin
        rdata_ff <= AXI_DW'(rd_byte);
        rresp_err_ff <= ~r_map;
      end
    end
  end

  // Scratch bytes; reset stands for the supply coming up from zero
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      scratch0_ff <= SCRATCH_RESET;
      scratch1_ff <= SCRATCH_RESET;
    end
    else if (lose)
    begin
      scratch0_ff <= SCRATCH_RESET; // see [RULE2]
      scratch1_ff <= SCRATCH_RESET;
    end
    else
    begin
      if (wr_scr0)
        scratch0_ff <= wbyte_ff; // see [RULE1]
      if (wr_scr1)
        scratch1_ff <= wbyte_ff;
    end
  end

  // Watchdog control and interrupt registers
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wdc_ff <= WDC_RESET;
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      wdc_ff <= nxt_wdc;
      irq_stat_ff <= nxt_irq_stat;
      if (wr_ien)
        irq_en_ff <= wbyte_ff[IRQ_W-1:0];
      irq_ff <= |(nxt_irq_stat & (wr_ien ? wbyte_ff[IRQ_W-1:0] : irq_en_ff));
    end
  end

  // Pin-facing outputs; the wake level leaves only in ordinary sleep
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wake_lvl_ff <= 1'b0;
      sink_ff <= 1'b0;
      sleep_irq_ff <= 1'b0;
    end
    else
    begin
      wake_lvl_ff <= ulp_sleep_wake; // see [RULE15]
      sink_ff <= ulp_armed;
      sleep_irq_ff <= ulp_sleep_wake; // see [RULE14]
    end
  end

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_err_ff ? RESP_SLVERR : RESP_OKAY;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_err_ff ? RESP_SLVERR : RESP_OKAY;
  assign wake_level_output_out = wake_lvl_ff;
  assign current_sink_out = sink_ff;
  assign sleep_wake_irq_out = sleep_irq_ff;
  assign irq_out = irq_ff;

  // Checks; first-source window is open while nothing is logged yet
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  wire first_ok = deep_sleep_in & ~wk.logged & ~wr_low & ~wr_high;

  property p_scr_hold;
    !lose && !wr_scr0 && !wr_scr1 |=> $stable(scratch0_ff) && $stable(scratch1_ff);
  endproperty
  a_scr_hold: assert property (p_scr_hold) else $error("scratch changed"); // see [RULE1]

  property p_scr_lose;
    lose |=> scratch0_ff == 8'h00 && scratch1_ff == 8'h00;
  endproperty
  a_scr_lose: assert property (p_scr_lose) else $error("scratch kept on loss"); // see [RULE2]

  property p_pin;
    first_ok && wk.src == 9'h100 |=> wk.flags[WK_PIN] ##1 wk.logged;
  endproperty
  a_pin: assert property (p_pin) else $error("pin wake not logged"); // see [RULE3]

  property p_fault;
    first_ok && wk.src == 9'h080 |=> wk.flags[WK_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not logged"); // see [RULE4]

  property p_ulp_ds;
    first_ok && ulp_fire && wk.src == 9'h020 |=> wk.flags[WK_ULP] && !sleep_irq_ff;
  endproperty
  a_ulp_ds: assert property (p_ulp_ds) else $error("deep ulp not logged"); // see [RULE5]

  property p_wdog;
    first_ok && wk.src == 9'h010 |=> wk.flags[WK_WDOG];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not logged"); // see [RULE6]

  property p_alarm;
    first_ok && wk.src == 9'h008 |=> wk.flags[WK_ALARM];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not logged"); // see [RULE7]

  property p_master_clear_pin;
    first_ok && wk.src == 9'h004 |=> wk.flags[WK_MASTER_CLEAR_PIN];
  endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear not logged"); // see [RULE8]

  property p_por;
    !deep_sleep_in && por_evt |=> wk.flags[WK_POR];
  endproperty
  a_por: assert property (p_por) else $error("power-on not logged"); // see [RULE10]

  property p_unimpl;
    !wk.flags[6] && !wk.flags[1];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // see [RULE11]

  property p_lvl;
    ulp_sleep_wake |=> wdc_ff[WDC_LVL] && sleep_irq_ff && wake_level_output_out;
  endproperty
  a_lvl: assert property (p_lvl) else $error("sleep wake not flagged"); // see [RULE12]

  property p_first;
    deep_sleep_in && wk.logged && !wr_low && !wr_high |=> $stable(wk.flags);
  endproperty
  a_first: assert property (p_first) else $error("second source logged"); // see [RULE18]

  property p_clr;
    wr_low && wbyte_ff == 8'h00 && !deep_sleep_in && !por_evt |=> wk.flags[7:0] == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared"); // see [RULE19]

  c_pin_wake: cover property (first_ok && pin_change_in ##1 wk.flags[WK_PIN]);
  c_sleep_wake: cover property (ulp_sleep_wake ##1 sleep_irq_ff);
  c_write: cover property (do_write ##1 bvalid_ff && s_axi_bready_in);
  c_irq: cover property (irq_ff);
endmodule : dswk_top

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import dswk_pkg::*;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [15:0] s_axi_awaddr_in = 16'h0000;
  logic s_axi_awvalid_in = 1'b0;
  logic s_axi_awready_out;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_wready_out;
  logic [1:0] s_axi_bresp_out;
  logic s_axi_bvalid_out;
  logic s_axi_bready_in = 1'b0;
  logic [15:0] s_axi_araddr_in = 16'h0000;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_arready_out;
  logic [31:0] s_axi_rdata_out;
  logic [1:0] s_axi_rresp_out;
  logic s_axi_rvalid_out;
  logic s_axi_rready_in = 1'b0;
  logic deep_sleep_in = 1'b0;
  logic sleep_in = 1'b0;
  logic [8:0] src = 9'h000;
  logic por_active_in = 1'b0;
  logic sense_low_in = 1'b0;
  logic core_brownout_in = 1'b0;
  logic deep_sleep_brownout_en_in = 1'b0;
  logic deep_sleep_brownout_trip_in = 1'b0;
  logic supply_cycle_in = 1'b0;
  logic wake_level_output_out;
  logic current_sink_out;
  logic sleep_wake_irq_out;
  logic irq_out;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // Event sources sit in one vector at their flag positions
  dswk_top i_dswk_top (
    .sys_clk_in, .nrst_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .deep_sleep_in, .sleep_in,
    .pin_change_in(src[WK_PIN]),
    .fault_in(src[WK_FAULT]),
    .ds_watchdog_timeout_in(src[WK_WDOG]),
    .alarm_in(src[WK_ALARM]),
    .master_clear_pin_in(src[WK_MASTER_CLEAR_PIN]),
    .por_active_in,
    .por_detect_in(src[WK_POR]),
    .sense_low_in, .core_brownout_in, .deep_sleep_brownout_en_in,
    .deep_sleep_brownout_trip_in, .supply_cycle_in,
    .wake_level_output_out, .current_sink_out, .sleep_wake_irq_out, .irq_out
  );

  // 50 MHz clock
  initial
  begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : tick

  // Write offers address and data together and holds each until taken
  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] re);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= {a, 2'b00};
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wstrb_in <= st;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge sys_clk_in);
      if (!aw && s_axi_awready_out === 1'b1)
      begin
        aw = 1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!w && s_axi_wready_out === 1'b1)
      begin
        w = 1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do @(posedge sys_clk_in); while (s_axi_bvalid_out !== 1'b1);
    check(32'(s_axi_bresp_out), 32'(re));
    s_axi_bready_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic [7:0] d, input logic [1:0] re);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= {a, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge sys_clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge sys_clk_in); while (s_axi_rvalid_out !== 1'b1);
    check(s_axi_rdata_out, {24'h0, d});
    check(32'(s_axi_rresp_out), 32'(re));
    s_axi_rready_in <= 1'b0;
  endtask : rd

  // One-cycle event, optionally inside a deep-sleep period
  task automatic ev(input logic [8:0] m, input logic ds);
    @(posedge sys_clk_in);
    deep_sleep_in <= ds;
    @(posedge sys_clk_in);
    src <= m;
    @(posedge sys_clk_in);
    src <= 9'h000;
    @(posedge sys_clk_in);
    deep_sleep_in <= 1'b0;
  endtask : ev

  task automatic t_reset();
    rd(IDX_WAKE_LOW, 8'h01, RESP_OKAY);
    rd(IDX_WAKE_HIGH, 8'h00, RESP_OKAY);
    rd(IDX_SCRATCH0, SCRATCH_RESET, RESP_OKAY);
    rd(14'h0F4C, 8'h00, RESP_SLVERR);
    wr(14'h0F4C, 8'h55, 4'h1, RESP_SLVERR);
    wr(IDX_WAKE_LOW, 8'hFF, 4'h1, RESP_OKAY);
    rd(IDX_WAKE_LOW, 8'hBD, RESP_OKAY);
    wr(IDX_WAKE_HIGH, 8'hFF, 4'h1, RESP_OKAY);
    rd(IDX_WAKE_HIGH, 8'h01, RESP_OKAY);
    wr(IDX_WAKE_LOW, 8'h00, 4'h1, RESP_OKAY);
    wr(IDX_WAKE_HIGH, 8'h00, 4'h1, RESP_OKAY);
    rd(IDX_WAKE_LOW, 8'h00, RESP_OKAY);
    $display("test reset done");
  endtask : t_reset

  // Each deep-sleep source but the low-power wake and power-on lands on its own flag, then clears by writing zero
  task automatic t_sources();
    int pos [5] = '{WK_FAULT, WK_WDOG, WK_ALARM, WK_MASTER_CLEAR_PIN, WK_PIN};
    logic [8:0] m;
    foreach (pos[i])
    begin
      m = 9'h001 << pos[i];
      ev(m, 1'b1);
      rd(IDX_WAKE_LOW, m[7:0], RESP_OKAY);
      rd(IDX_WAKE_HIGH, {7'h0, m[8]}, RESP_OKAY);
      wr(m[8] ? IDX_WAKE_HIGH : IDX_WAKE_LOW, 8'h00, 4'h1, RESP_OKAY);
      rd(m[8] ? IDX_WAKE_HIGH : IDX_WAKE_LOW, 8'h00, RESP_OKAY);
    end
    $display("test sources done");
  endtask : t_sources

  // Two sources one after the other inside one deep-sleep period; only the first logs
  task automatic t_first();
    @(posedge sys_clk_in);
    deep_sleep_in <= 1'b1;
    @(posedge sys_clk_in);
    src <= 9'h008;
    @(posedge sys_clk_in);
    src <= 9'h080;
    @(posedge sys_clk_in);
    src <= 9'h000;
    deep_sleep_in <= 1'b0;
    rd(IDX_WAKE_LOW, 8'h08, RESP_OKAY);
    wr(IDX_WAKE_LOW, 8'h00, 4'h1, RESP_OKAY);
    ev(9'h014, 1'b1);
    rd(IDX_WAKE_LOW, 8'h04, RESP_OKAY);
    wr(IDX_WAKE_LOW, 8'h00, 4'h1, RESP_OKAY);
    ev(9'h008, 1'b0);
    rd(IDX_WAKE_LOW, 8'h00, RESP_OKAY);
    ev(9'h001, 1'b0);
    rd(IDX_WAKE_LOW, 8'h00, RESP_OKAY);
    por_active_in <= 1'b1;
    ev(9'h001, 1'b0);
    por_active_in <= 1'b0;
    rd(IDX_WAKE_LOW, 8'h01, RESP_OKAY);
    wr(IDX_WAKE_LOW, 8'h00, 4'h1, RESP_OKAY);
    $display("test first-source done");
  endtask : t_first

  task automatic t_ulp();
    wr(IDX_WDOG_CTRL, 8'h14, 4'h1, RESP_OKAY);
    tick(2);
    check(32'(current_sink_out), 32'h1);
    @(posedge sys_clk_in);
    sleep_in <= 1'b1;
    sense_low_in <= 1'b1;
    tick(2);
    check(32'(wake_level_output_out), 32'h1);
    check(32'(sleep_wake_irq_out), 32'h1);
    sleep_in <= 1'b0;
    sense_low_in <= 1'b0;
    tick(2);
    check(32'(wake_level_output_out), 32'h0);
    rd(IDX_WDOG_CTRL, 8'h34, RESP_OKAY);
    rd(IDX_WAKE_LOW, 8'h00, RESP_OKAY);
    wr(IDX_WDOG_CTRL, 8'h14, 4'h1, RESP_OKAY);
    // Sleep stays requested too, so deep sleep must still win over the level flag
    @(posedge sys_clk_in);
    deep_sleep_in <= 1'b1;
    sleep_in <= 1'b1;
    sense_low_in <= 1'b1;
    tick(3);
    check(32'(sleep_wake_irq_out), 32'h0);
    deep_sleep_in <= 1'b0;
    sleep_in <= 1'b0;
    sense_low_in <= 1'b0;
    rd(IDX_WAKE_LOW, 8'h20, RESP_OKAY);
    rd(IDX_WDOG_CTRL, 8'h14, RESP_OKAY);
    wr(IDX_WAKE_LOW, 8'h00, 4'h1, RESP_OKAY);
    $display("test low-power wake done");
  endtask : t_ulp

  task automatic t_irq();
    rd(IDX_IRQ_STAT, 8'h03, RESP_OKAY);
    wr(IDX_IRQ_EN, 8'h01, 4'h1, RESP_OKAY);
    tick(2);
    check(32'(irq_out), 32'h1);
    wr(IDX_IRQ_EN, 8'h00, 4'h1, RESP_OKAY);
    tick(2);
    check(32'(irq_out), 32'h0);
    wr(IDX_IRQ_EN, 8'h01, 4'h1, RESP_OKAY);
    wr(IDX_IRQ_CLR, 8'h07, 4'h1, RESP_OKAY);
    tick(2);
    check(32'(irq_out), 32'h0);
    rd(IDX_IRQ_STAT, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_CLR, 8'h00, RESP_OKAY);
    $display("test interrupt done");
  endtask : t_irq

  // Retention: only the three documented supply events may wipe the bytes
  task automatic t_scratch();
    wr(IDX_SCRATCH0, 8'hA5, 4'h1, RESP_OKAY);
    wr(IDX_SCRATCH1, 8'h5A, 4'h1, RESP_OKAY);
    wr(IDX_SCRATCH0, 8'hFF, 4'h0, RESP_OKAY);
    rd(IDX_SCRATCH0, 8'hA5, RESP_OKAY);
    @(posedge sys_clk_in);
    deep_sleep_in <= 1'b1;
    deep_sleep_brownout_trip_in <= 1'b1;
    core_brownout_in <= 1'b1;
    tick(3);
    deep_sleep_brownout_trip_in <= 1'b0;
    core_brownout_in <= 1'b0;
    deep_sleep_in <= 1'b0;
    rd(IDX_SCRATCH1, 8'h5A, RESP_OKAY);
    core_brownout_in <= 1'b1;
    tick(1);
    core_brownout_in <= 1'b0;
    rd(IDX_SCRATCH0, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_STAT, 8'h04, RESP_OKAY);
    wr(IDX_SCRATCH1, 8'h3C, 4'h1, RESP_OKAY);
    deep_sleep_in <= 1'b1;
    deep_sleep_brownout_en_in <= 1'b1;
    deep_sleep_brownout_trip_in <= 1'b1;
    tick(2);
    deep_sleep_in <= 1'b0;
    deep_sleep_brownout_trip_in <= 1'b0;
    rd(IDX_SCRATCH1, 8'h00, RESP_OKAY);
    wr(IDX_SCRATCH0, 8'hC3, 4'h1, RESP_OKAY);
    supply_cycle_in <= 1'b1;
    tick(1);
    supply_cycle_in <= 1'b0;
    rd(IDX_SCRATCH0, 8'h00, RESP_OKAY);
    $display("test scratch done");
  endtask : t_scratch

  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    tick(1);
    t_reset();
    t_sources();
    t_first();
    t_ulp();
    t_irq();
    t_scratch();
    tally_and_finish();
  end
endmodule : tb
